// ===== lsg_pkg.sv
// Package: register map, field layout and timing for the line-side gain register bank
package lsg_pkg;
  // Word indices; byte addresses below are index times four (so every offset is a multiple of four)
  localparam logic [3:0] IDX_REV = 4'hd;
  localparam logic [3:0] IDX_VER = 4'he;
  localparam logic [3:0] IDX_GAIN = 4'hf;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h1;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h2;
  localparam logic [3:0] IDX_CTRL = 4'h3;
  localparam int ADDR_W = 6;
  localparam logic [5:0] ADDR_REV = {IDX_REV, 2'b00};
  localparam logic [5:0] ADDR_VER = {IDX_VER, 2'b00};
  localparam logic [5:0] ADDR_GAIN = {IDX_GAIN, 2'b00};
  localparam logic [5:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [5:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [5:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  // Revision register fields
  localparam int REV_INTL_BIT = 6;
  localparam int REV_CHIP_LSB = 2;
  localparam int REV_BOOST_BIT = 1;
  localparam int REV_CUT_BIT = 0;
  // Verification register fields
  localparam int VER_PEND_BIT = 2;
  localparam int VER_RUN_BIT = 1;
  localparam int VER_RES_BIT = 0;
  // Gain register fields
  localparam int GAIN_TXM_BIT = 7;
  localparam int GAIN_ATX_LSB = 4;
  localparam int GAIN_RXM_BIT = 3;
  localparam int GAIN_ARX_LSB = 0;
  // Interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_BAD_BIT = 1;
  // Reset values
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [1:0] LEGACY_RST = 2'b00;
  localparam logic [1:0] MASK_RST = 2'b00;
  // Verification duration
  localparam int CLK_MHZ = 50;
  localparam int VERIFY_US = 10;
  localparam int VERIFY_CYC = VERIFY_US * CLK_MHZ;
  // Gain codes in tenths of dB
  localparam logic [6:0] DB_0 = 7'h00;
  localparam logic [6:0] DB_1 = 7'h0a;
  localparam logic [6:0] DB_2P2 = 7'h16;
  localparam logic [6:0] DB_3 = 7'h1e;
  localparam logic [6:0] DB_3P5 = 7'h23;
  localparam logic [6:0] DB_5 = 7'h32;
  localparam logic [6:0] DB_6 = 7'h3c;
  localparam logic [6:0] DB_9 = 7'h5a;
  localparam logic [6:0] DB_12 = 7'h78;
endpackage

// ===== lsg_decode.sv
// Gain field decoder: three-bit selector to tenths of dB
`timescale 1ns/1ps
module lsg_decode (
  // Selector
  input wire logic [2:0] sel_i,
  input wire logic monitor_i,
  // Result
  output logic [6:0] tenth_db_o
);
  always_comb begin
    if (sel_i[2]) begin
      tenth_db_o = monitor_i ? lsg_pkg::DB_5 : lsg_pkg::DB_12;
    end else begin
      unique case (sel_i[1:0])
        2'b00: tenth_db_o = lsg_pkg::DB_0;
        2'b01: tenth_db_o = monitor_i ? lsg_pkg::DB_1 : lsg_pkg::DB_3;
        2'b10: tenth_db_o = monitor_i ? lsg_pkg::DB_2P2 : lsg_pkg::DB_6;
        2'b11: tenth_db_o = monitor_i ? lsg_pkg::DB_3P5 : lsg_pkg::DB_9;
      endcase
    end
  end
endmodule

// ===== lsg_regs.sv
// Line-side revision, verification and gain register bank on Avalon-MM
`timescale 1ns/1ps
module lsg_regs #(
  parameter logic [3:0] CHIP_REV = 4'h0,  // Arbitrary value
  parameter logic INTL_SUPPORT = 1'b1,
  parameter int VERIFY_CYCLES = lsg_pkg::VERIFY_CYC
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Avalon-MM slave
  input wire logic [lsg_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Line side
  input wire logic LINE_ENABLE_I,
  input wire logic DEVICE_BAD_I,
  input wire logic OFF_HOOK_I,
  // Analog path controls
  output logic TX_MUTE_O,
  output logic RX_MUTE_O,
  output logic [6:0] TX_ATTEN_O,
  output logic [6:0] RX_GAIN_O,
  output logic [6:0] MON_ATTEN_O,
  output logic MON_ACTIVE_O,
  output logic LEGACY_RX_BOOST_O,
  output logic LEGACY_TX_CUT_O,
  output logic DATA_ENABLE_O,
  // Interrupt
  output logic IRQ_O
);
  // The run counter is sixteen bits wide and needs at least one cycle
  if (VERIFY_CYCLES < 1 || VERIFY_CYCLES > 65535) begin : g_bad_cycles
    $error("VERIFY_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    VS_IDLE = 2'b00,
    VS_RUN = 2'b01,
    VS_DONE = 2'b10
  } lsg_vstate_t;

  typedef struct packed {
    lsg_vstate_t vstate;
    logic [15:0] vcount;
    logic result;
    logic [7:0] gain;
    logic rx_boost;
    logic tx_cut;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic data_gate;
    logic ack;
    logic [31:0] rdata;
  } lsg_state_t;

  lsg_state_t r;
  lsg_state_t next_r;
  logic [7:0] rd_byte;
  logic [6:0] tx_db;
  logic [6:0] rx_db;
  logic [6:0] mon_db;
  logic access;

  assign access = (AVS_READ_I | AVS_WRITE_I) & ~r.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit attenuation, receive gain and monitor attenuation decode
  lsg_decode u_tx (
    .sel_i(r.gain[lsg_pkg::GAIN_ATX_LSB +: 3]),
    .monitor_i(1'b0),
    .tenth_db_o(tx_db)
  );
  lsg_decode u_rx (
    .sel_i(r.gain[lsg_pkg::GAIN_ARX_LSB +: 3]),
    .monitor_i(1'b0),
    .tenth_db_o(rx_db)
  );
  lsg_decode u_mon (
    .sel_i(r.gain[lsg_pkg::GAIN_ARX_LSB +: 3]),
    .monitor_i(1'b1),
    .tenth_db_o(mon_db)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_byte = 8'h00;
    unique case (AVS_ADDRESS_I)
      lsg_pkg::ADDR_REV: begin
        rd_byte[lsg_pkg::REV_INTL_BIT] = INTL_SUPPORT;
        rd_byte[lsg_pkg::REV_CHIP_LSB +: 4] = CHIP_REV;
        rd_byte[lsg_pkg::REV_BOOST_BIT] = r.rx_boost;
        rd_byte[lsg_pkg::REV_CUT_BIT] = r.tx_cut;
      end
      lsg_pkg::ADDR_VER: begin
        rd_byte[lsg_pkg::VER_PEND_BIT] = (r.vstate != VS_DONE);
        rd_byte[lsg_pkg::VER_RUN_BIT] = (r.vstate == VS_RUN);
        rd_byte[lsg_pkg::VER_RES_BIT] = r.result;
      end
      lsg_pkg::ADDR_GAIN: rd_byte = r.gain;
      lsg_pkg::ADDR_IRQ_STAT: rd_byte[1:0] = r.irq_stat;
      lsg_pkg::ADDR_IRQ_MASK: rd_byte[1:0] = r.irq_mask;
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.ack = access;
    unique case (r.vstate)
      VS_IDLE: begin
        if (LINE_ENABLE_I) begin
          next_r.vstate = VS_RUN;
          next_r.vcount = 16'(VERIFY_CYCLES - 1);
        end
      end
      VS_RUN: begin
        if (r.vcount == 16'h0000) begin
          next_r.vstate = VS_DONE;
          next_r.result = DEVICE_BAD_I;
          next_r.data_gate = ~DEVICE_BAD_I;
        end else begin
          next_r.vcount = r.vcount - 16'h0001;
        end
      end
      VS_DONE: next_r.vstate = VS_DONE;
      default: next_r.vstate = VS_IDLE;
    endcase
    if (access && AVS_READ_I) begin
      next_r.rdata = {24'h00_0000, rd_byte};
      // Read of the status register clears it
      if (AVS_ADDRESS_I == lsg_pkg::ADDR_IRQ_STAT) begin
        next_r.irq_stat = 2'b00;
      end
    end
    if (access && AVS_WRITE_I && AVS_BYTEENABLE_I[0]) begin
      unique case (AVS_ADDRESS_I)
        lsg_pkg::ADDR_REV: begin
          next_r.rx_boost = AVS_WRITEDATA_I[lsg_pkg::REV_BOOST_BIT];
          next_r.tx_cut = AVS_WRITEDATA_I[lsg_pkg::REV_CUT_BIT];
        end
        lsg_pkg::ADDR_GAIN: next_r.gain = AVS_WRITEDATA_I[7:0];
        lsg_pkg::ADDR_IRQ_MASK: next_r.irq_mask = AVS_WRITEDATA_I[1:0];
        default: next_r.gain = next_r.gain;
      endcase
    end
    // Set wins over the read clear
    if (r.vstate == VS_RUN && r.vcount == 16'h0000) begin
      next_r.irq_stat[lsg_pkg::IRQ_DONE_BIT] = 1'b1;
      if (DEVICE_BAD_I) begin
        next_r.irq_stat[lsg_pkg::IRQ_BAD_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r <= '{vstate: VS_IDLE, vcount: 16'h0000, result: 1'b0,
             gain: lsg_pkg::GAIN_RST, rx_boost: lsg_pkg::LEGACY_RST[1],
             tx_cut: lsg_pkg::LEGACY_RST[0], irq_stat: 2'b00,
             irq_mask: lsg_pkg::MASK_RST, data_gate: 1'b0, ack: 1'b0,
             rdata: 32'h0000_0000};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One wait cycle keeps read data registered
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~r.ack;
  assign AVS_READDATA_O = r.rdata;
  assign TX_MUTE_O = r.gain[lsg_pkg::GAIN_TXM_BIT];
  assign RX_MUTE_O = r.gain[lsg_pkg::GAIN_RXM_BIT];
  assign TX_ATTEN_O = tx_db;
  assign RX_GAIN_O = rx_db;
  assign MON_ATTEN_O = mon_db;
  assign MON_ACTIVE_O = ~OFF_HOOK_I;
  assign LEGACY_RX_BOOST_O = r.rx_boost;
  assign LEGACY_TX_CUT_O = r.tx_cut;
  assign DATA_ENABLE_O = r.data_gate;
  assign IRQ_O = |(r.irq_stat & r.irq_mask);
endmodule

// ===== lsg_props.sv
// Port checker for the line-side gain register bank
`timescale 1ns/1ps
module lsg_props #(parameter int VERIFY_CYCLES = 4) (
  // Clock and bus
  input wire logic CLK_I, RST_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O,
  input wire logic [31:0] AVS_READDATA_O,
  // Line side
  input wire logic LINE_ENABLE_I, DEVICE_BAD_I, OFF_HOOK_I, MON_ACTIVE_O, DATA_ENABLE_O,
  input wire logic [6:0] TX_ATTEN_O, MON_ATTEN_O
);
  // Slack beyond the run length covers the enable-to-start latency
  localparam int VMAX = VERIFY_CYCLES + 6;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_ack_next: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |->
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("bus answer late");
  a_upper_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O |->
    AVS_READDATA_O[31:8] == 24'h00_0000) else $error("upper read bits set");
  a_mon_hook: assert property (MON_ACTIVE_O == !OFF_HOOK_I)
    else $error("monitor not tied to hook");
  a_tx_codes: assert property (TX_ATTEN_O inside {7'h00, 7'h1e, 7'h3c, 7'h5a, 7'h78})
    else $error("bad transmit step");
  a_mon_codes: assert property (MON_ATTEN_O inside {7'h00, 7'h0a, 7'h16, 7'h23, 7'h32})
    else $error("bad monitor step");
  a_good_enable: assert property ($rose(LINE_ENABLE_I) && !DEVICE_BAD_I |->
    ##[1:VMAX] DATA_ENABLE_O) else $error("no data after check");
  a_bad_blocks: assert property (DEVICE_BAD_I && !DATA_ENABLE_O |=> !DATA_ENABLE_O)
    else $error("bad device passes data");
  a_result_held: assert property (DATA_ENABLE_O |=> DATA_ENABLE_O)
    else $error("data enable dropped");
  cover property ($rose(DATA_ENABLE_O));
  cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
  cover property (MON_ACTIVE_O && MON_ATTEN_O == 7'h32);
endmodule
bind lsg_regs lsg_props #(.VERIFY_CYCLES(VERIFY_CYCLES)) u_props (.CLK_I(CLK_I),
  .RST_I(RST_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .AVS_READDATA_O(AVS_READDATA_O),
  .LINE_ENABLE_I(LINE_ENABLE_I), .DEVICE_BAD_I(DEVICE_BAD_I), .OFF_HOOK_I(OFF_HOOK_I),
  .MON_ACTIVE_O(MON_ACTIVE_O), .DATA_ENABLE_O(DATA_ENABLE_O),
  .TX_ATTEN_O(TX_ATTEN_O), .MON_ATTEN_O(MON_ATTEN_O));

// ===== lsg_host.sv
// Avalon-MM host model for the register bank
`timescale 1ns/1ps
module lsg_host (
  // Bus
  input wire logic clk_i, wait_i,
  input wire logic [31:0] rdata_i,
  output logic read_o = 1'b0,
  output logic write_o = 1'b0,
  output logic [5:0] addr_o = 6'h00,
  output logic [31:0] wdata_o = 32'h0000_0000,
  output logic [3:0] be_o = 4'hf
);
  task automatic xf(input logic we, input logic [5:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= {24'h00_0000, d};
    read_o <= !we;
    write_o <= we;
    @(posedge clk_i);
    // Only the bench watchdog ends a hung wait
    while (wait_i !== 1'b0) begin
      @(posedge clk_i);
    end
    q = rdata_i[7:0];
    read_o <= 1'b0;
    write_o <= 1'b0;
    // Released data must not look valid
    wdata_o <= ~wdata_o;
    @(negedge clk_i);
  endtask
endmodule

// ===== lsg_regs_tb.sv
// Self-checking testbench for the line-side gain register bank
`timescale 1ns/1ps
module lsg_regs_tb;
  logic CLK_I = 1'b0, RST_I = 1'b1, LINE_ENABLE_I = 1'b0, DEVICE_BAD_I = 1'b0, OFF_HOOK_I = 1'b0;
  logic rd, wr, wq, tx_m, rx_m, mon_a, lb, lc, den, irq;
  logic [5:0] addr;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  logic [6:0] txa, rxg, mona;
  logic [7:0] q, d;
  int errors = 0;
  int compares = 0;
  initial begin
    forever #10 CLK_I = ~CLK_I;
  end
  lsg_regs #(.CHIP_REV(4'ha), .INTL_SUPPORT(1'b1), .VERIFY_CYCLES(20)) uut (.CLK_I(CLK_I),
    .RST_I(RST_I), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wq), .LINE_ENABLE_I(LINE_ENABLE_I), .DEVICE_BAD_I(DEVICE_BAD_I),
    .OFF_HOOK_I(OFF_HOOK_I), .TX_MUTE_O(tx_m), .RX_MUTE_O(rx_m), .TX_ATTEN_O(txa),
    .RX_GAIN_O(rxg), .MON_ATTEN_O(mona), .MON_ACTIVE_O(mon_a), .LEGACY_RX_BOOST_O(lb),
    .LEGACY_TX_CUT_O(lc), .DATA_ENABLE_O(den), .IRQ_O(irq));
  lsg_host host (.clk_i(CLK_I), .wait_i(wq), .rdata_i(rdat), .read_o(rd), .write_o(wr),
    .addr_o(addr), .wdata_o(wd), .be_o(be));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] gd(input logic [2:0] c, input logic m);
    logic [6:0] g[4];
    logic [6:0] a[4];
    g = '{lsg_pkg::DB_0, lsg_pkg::DB_3, lsg_pkg::DB_6, lsg_pkg::DB_9};
    a = '{lsg_pkg::DB_0, lsg_pkg::DB_1, lsg_pkg::DB_2P2, lsg_pkg::DB_3P5};
    if (c[2]) return {1'b0, m ? lsg_pkg::DB_5 : lsg_pkg::DB_12};
    return {1'b0, m ? a[c[1:0]] : g[c[1:0]]};
  endfunction
  task automatic reset_dut(input logic bad);
    @(posedge CLK_I);
    RST_I <= 1'b1;
    LINE_ENABLE_I <= 1'b0;
    DEVICE_BAD_I <= bad;
    repeat (16) @(posedge CLK_I);
    RST_I <= 1'b0;
  endtask
  task automatic t_ids();
    host.xf(0, lsg_pkg::ADDR_REV, 8'h00, q);
    chk("rev", 8'h68, q);
    host.xf(0, lsg_pkg::ADDR_VER, 8'h00, q);
    chk("ver idle", 8'h04, q);
    host.xf(1, lsg_pkg::ADDR_REV, 8'hff, q);
    host.xf(0, lsg_pkg::ADDR_REV, 8'h00, q);
    chk("rev wr", 8'h6b, q);
    chk("legacy", 8'h03, {6'h00, lb, lc});
    host.xf(1, lsg_pkg::ADDR_REV, 8'h00, q);
    chk("legacy off", 8'h00, {6'h00, lb, lc});
    host.xf(1, lsg_pkg::ADDR_VER, 8'hff, q);
    host.xf(0, lsg_pkg::ADDR_VER, 8'h00, q);
    chk("ver wr", 8'h04, q);
    host.xf(1, 6'h0c, 8'hff, q);
    host.xf(0, 6'h0c, 8'h00, q);
    chk("unmapped", 8'h00, q);
    $display("t_ids done");
  endtask
  task automatic t_verify(input logic bad);
    reset_dut(bad);
    host.xf(1, lsg_pkg::ADDR_IRQ_MASK, {6'h00, !bad, !bad}, q);
    @(posedge CLK_I);
    LINE_ENABLE_I <= 1'b1;
    host.xf(0, lsg_pkg::ADDR_VER, 8'h00, q);
    chk("running", 8'h06, q);
    chk1("data early", 1'b0, den);
    repeat (30) @(posedge CLK_I);
    // Result read once both flags are clear
    host.xf(0, lsg_pkg::ADDR_VER, 8'h00, q);
    chk("ver end", {7'h00, bad}, q);
    chk1("data", !bad, den);
    chk1("irq", !bad, irq);
    host.xf(0, lsg_pkg::ADDR_IRQ_STAT, 8'h00, q);
    chk("status", {6'h00, bad, 1'b1}, q);
    chk1("irq clr", 1'b0, irq);
    host.xf(0, lsg_pkg::ADDR_IRQ_STAT, 8'h00, q);
    chk("status clr", 8'h00, q);
    $display("t_verify done");
  endtask
  // Legacy bits stay zero while the fields are used
  task automatic t_gain();
    host.xf(0, lsg_pkg::ADDR_GAIN, 8'h00, q);
    chk("gain rst", lsg_pkg::GAIN_RST, q);
    for (int i = 0; i < 16; i++) begin
      d = {i[3], i[2:0], !i[3], 3'(i + 3)};
      @(posedge CLK_I);
      OFF_HOOK_I <= i[1];
      host.xf(1, lsg_pkg::ADDR_GAIN, d, q);
      chk1("tx mute", d[7], tx_m);
      chk1("rx mute", d[3], rx_m);
      chk("tx att", gd(d[6:4], 1'b0), {1'b0, txa});
      chk("rx gain", gd(d[2:0], 1'b0), {1'b0, rxg});
      chk("mon att", gd(d[2:0], 1'b1), {1'b0, mona});
      chk1("mon on", !i[1], mon_a);
      host.xf(0, lsg_pkg::ADDR_GAIN, 8'h00, q);
      chk("gain rd", d, q);
    end
    $display("t_gain done");
  endtask
  initial begin
    repeat (20000) @(posedge CLK_I);
    errors++;
    wrap_up();
  end
  initial begin
    reset_dut(1'b0);
    t_ids();
    t_verify(1'b0);
    t_verify(1'b1);
    t_gain();
    wrap_up();
  end
endmodule
